// File: sync_serial_consts.svh
`ifndef SYNC_SERIAL_CONSTS_SVH
`define SYNC_SERIAL_CONSTS_SVH

// register byte addresses
`define ADDR_RX_STATUS_CTRL 8'h00
`define ADDR_TX_HOLDING 8'h04
`define ADDR_TX_STATUS_CTRL 8'h08
`define ADDR_BAUD_CTRL 8'h0C
`define ADDR_BAUD_DIV_HIGH 8'h10
`define ADDR_BAUD_DIV_LOW 8'h14
`define ADDR_RX_DATA 8'h18
`define ADDR_IRQ_STATUS 8'h1C
`define ADDR_IRQ_MASK 8'h20
`define ADDR_CORE_IRQ_CTRL 8'h24

// receive_status_control fields
`define RXC_PORT_ENABLE 7
`define RXC_RX_NINTH_ENABLE 6
`define RXC_SINGLE_RX_ENABLE 5
`define RXC_CONT_RX_ENABLE 4
`define RXC_OVERRUN 1
`define RXC_RX_NINTH_BIT 0

// transmit_status_control fields
`define TXC_CLOCK_SOURCE 7
`define TXC_TX_NINTH_ENABLE 6
`define TXC_TX_ARM 5
`define TXC_SYNC_SELECT 4
`define TXC_SHIFT_EMPTY 1
`define TXC_TX_NINTH_BIT 0

// core interrupt control fields
`define CIC_TX_IRQ_ENABLE 0
`define CIC_RX_IRQ_ENABLE 1
`define CIC_PERIPH_IRQ_ENABLE 2
`define CIC_GLOBAL_IRQ_ENABLE 3
`define CIC_TX_BUFFER_FLAG 4
`define CIC_RX_AVAIL_FLAG 5

// sticky event bits
`define EVT_RX_CHAR 0
`define EVT_TX_BUFFER 1
`define EVT_OVERRUN 2

`define RESET_BYTE 8'h00
`define RESET_EVT 3'h0
`define BITS_8 4'h8
`define BITS_9 4'h9
`define FIFO_DEPTH 2'h2

`endif

// File: sync_serial_pkg.sv
`default_nettype none

package sync_serial_pkg;

	typedef enum logic [1:0] {LINK_OFF, LINK_TX, LINK_RX} link_mode_e;

	typedef logic [8:0] char_t;

	typedef struct packed {
		logic port_enable;
		logic rx_ninth_enable;
		logic single_rx_enable;
		logic continuous_rx_enable;
	} rx_ctrl_s;

	typedef struct packed {
		logic clock_source_select;
		logic tx_ninth_enable;
		logic tx_arm;
		logic sync_select;
		logic tx_ninth_bit;
	} tx_ctrl_s;

	typedef struct packed {
		logic global_irq_enable;
		logic peripheral_irq_enable;
		logic rx_irq_enable;
		logic tx_irq_enable;
	} irq_en_s;

endpackage

`default_nettype wire

// File: pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;

endmodule

`default_nettype wire

// File: rx_fifo.sv
`timescale 1ns/10ps
`default_nettype none
`include "sync_serial_consts.svh"

// two-entry queue; the top entry is itself the output register
module rx_fifo (
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic push,
	input wire sync_serial_pkg::char_t din,
	input wire logic pop,
	output sync_serial_pkg::char_t dout,
	output logic [1:0] count
);

	sync_serial_pkg::char_t top_reg, top_next;
	sync_serial_pkg::char_t second_reg, second_next;
	logic [1:0] count_reg, count_next;

	always_comb begin
		top_next = top_reg;
		second_next = second_reg;
		count_next = count_reg;
		if (flush) begin
			count_next = 2'h0;
		end else if (pop && count_reg != 2'h0) begin
			top_next = second_reg;
			if (push && count_reg == 2'h1) begin
				top_next = din;
			end else if (push) begin
				second_next = din;
			end else begin
				count_next = count_reg - 2'h1;
			end
		end else if (push && count_reg != `FIFO_DEPTH) begin
			if (count_reg == 2'h0) begin
				top_next = din;
			end else begin
				second_next = din;
			end
			count_next = count_reg + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			top_reg <= '0;
			second_reg <= '0;
			count_reg <= 2'h0;
		end else begin
			top_reg <= top_next;
			second_reg <= second_next;
			count_reg <= count_next;
		end
	end

	assign dout = top_reg;
	assign count = count_reg;

endmodule

`default_nettype wire

// File: sync_serial_slave_port.sv
// Overview of operation
// (RULE1) in sleep, first character shifts out at once
// (RULE2) transmit buffer flag clear while holding full
// (RULE3) after shifting, load waiting character, set flag
// (RULE4) transmit flag wakes core; global enable interrupts
// (RULE5) slave when sync, enabled, clock source clear
// (RULE6) transmit only with both receive enables clear
// (RULE7) arm enables transmit; ninth enable adds bit
// (RULE8) holding write starts character transmission
// (RULE9) continuous receive keeps receiver accepting until overrun
// (RULE10) single receive enable ignored in slave
// (RULE11) reception continues during sleep into data register
// (RULE12) receive interrupt wakes core; global enable vectors
// (RULE13) completed character sets receive flag, interrupt
// (RULE14) ninth receive enable gives nine-bit characters
// (RULE15) overrun cleared by receive or port disable
// (RULE16) master clocks; change leading, sample trailing
// (RULE17) two-entry FIFO; third sets overrun, blocks
// (RULE18) ninth bit field shows top unread character
// (RULE19) receive flag holds while FIFO not empty
`timescale 1ns/10ps
`default_nettype none
`include "sync_serial_consts.svh"

module sync_serial_slave_port (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic SLEEP,
	input wire logic CLOCK_LINE_PIN,
	input wire logic DATA_LINE_IN,
	output logic DATA_LINE_OUT,
	output logic DATA_LINE_OE,
	output logic IRQ,
	output logic WAKE,
	output logic CPU_INT
);

	////////////////////////////////////////////////////////////////////////////
	// declarations

	logic [1:0] pins_s;
	logic ck_s, dt_s;
	logic ck_prev_reg, ck_prev_next;
	logic ck_rise, ck_fall;

	sync_serial_pkg::rx_ctrl_s rxc_reg, rxc_next;
	sync_serial_pkg::tx_ctrl_s txc_reg, txc_next;
	sync_serial_pkg::irq_en_s ien_reg, ien_next;
	logic [7:0] baud_ctrl_reg, baud_ctrl_next;
	logic [7:0] baud_hi_reg, baud_hi_next;
	logic [7:0] baud_lo_reg, baud_lo_next;
	logic [2:0] evt_reg, evt_next;
	logic [2:0] mask_reg, mask_next;

	logic [7:0] hold_reg, hold_next;
	logic hold_full_reg, hold_full_next;
	sync_serial_pkg::char_t tx_shift_reg, tx_shift_next;
	logic tx_busy_reg, tx_busy_next;
	logic [3:0] tx_cnt_reg, tx_cnt_next;
	logic dt_out_reg, dt_out_next;
	logic dt_oe_reg, dt_oe_next;

	sync_serial_pkg::char_t rx_shift_reg, rx_shift_next;
	logic [3:0] rx_cnt_reg, rx_cnt_next;
	logic overrun_reg, overrun_next;

	logic ready_reg, ready_next;
	logic slverr_reg, slverr_next;
	logic [31:0] rdata_reg, rdata_next;
	logic irq_reg, irq_next;
	logic wake_reg, wake_next;
	logic cpu_int_reg, cpu_int_next;

	sync_serial_pkg::link_mode_e mode;
	logic commit, wr, rd_pop, mapped;
	logic tx_load, rx_push, ovr_event;
	logic tx_flag, rx_flag;
	logic [3:0] tx_bits, rx_bits;
	sync_serial_pkg::char_t rx_char, fifo_top;
	logic [1:0] fifo_count;
	logic [7:0] rd_byte;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and clock edge detection

	pin_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.clk(CLK),
		.rst(SYS_RST),
		.d({CLOCK_LINE_PIN, DATA_LINE_IN}),
		.q(pins_s)
	);

	assign ck_s = pins_s[1];
	assign dt_s = pins_s[0];
	assign ck_prev_next = ck_s;
	assign ck_rise = ck_s && !ck_prev_reg;
	assign ck_fall = !ck_s && ck_prev_reg;

	////////////////////////////////////////////////////////////////////////////
	// mode decode

	always_comb begin
		mode = sync_serial_pkg::LINK_OFF;
		if (rxc_reg.port_enable && txc_reg.sync_select && !txc_reg.clock_source_select) begin // RULE5
			if (rxc_reg.continuous_rx_enable) begin // RULE9 RULE10
				mode = sync_serial_pkg::LINK_RX;
			end else if (!rxc_reg.single_rx_enable && txc_reg.tx_arm) begin // RULE6 RULE7
				mode = sync_serial_pkg::LINK_TX;
			end
		end
	end

	assign tx_bits = txc_reg.tx_ninth_enable ? `BITS_9 : `BITS_8; // RULE7
	assign rx_bits = rxc_reg.rx_ninth_enable ? `BITS_9 : `BITS_8; // RULE14
	assign tx_flag = rxc_reg.port_enable && txc_reg.tx_arm && !hold_full_reg; // RULE2
	assign rx_flag = fifo_count != 2'h0; // RULE19

	////////////////////////////////////////////////////////////////////////////
	// apb decode; writes and pops take effect at the edge that samples pready

	assign commit = PSEL && PENABLE && ready_reg;
	assign wr = commit && PWRITE;
	assign rd_pop = commit && !PWRITE && PADDR == `ADDR_RX_DATA;

	always_comb begin
		mapped = 1'b1;
		rd_byte = `RESET_BYTE;
		unique case (PADDR)
			`ADDR_RX_STATUS_CTRL: rd_byte = {rxc_reg, 2'h0, overrun_reg, fifo_top[8]}; // RULE18
			`ADDR_TX_HOLDING: rd_byte = `RESET_BYTE;
			`ADDR_TX_STATUS_CTRL: rd_byte = {txc_reg[4:1], 2'h0, !tx_busy_reg, txc_reg.tx_ninth_bit};
			`ADDR_BAUD_CTRL: rd_byte = baud_ctrl_reg;
			`ADDR_BAUD_DIV_HIGH: rd_byte = baud_hi_reg;
			`ADDR_BAUD_DIV_LOW: rd_byte = baud_lo_reg;
			`ADDR_RX_DATA: rd_byte = fifo_top[7:0];
			`ADDR_IRQ_STATUS: rd_byte = {5'h00, evt_reg};
			`ADDR_IRQ_MASK: rd_byte = {5'h00, mask_reg};
			`ADDR_CORE_IRQ_CTRL: rd_byte = {2'h0, rx_flag, tx_flag, ien_reg};
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		ready_next = 1'b0;
		slverr_next = 1'b0;
		rdata_next = rdata_reg;
		if (PSEL && PENABLE && !ready_reg) begin
			ready_next = 1'b1;
			slverr_next = !mapped;
			rdata_next = {24'h00_0000, rd_byte};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration registers

	always_comb begin
		rxc_next = rxc_reg;
		txc_next = txc_reg;
		ien_next = ien_reg;
		baud_ctrl_next = baud_ctrl_reg;
		baud_hi_next = baud_hi_reg;
		baud_lo_next = baud_lo_reg;
		mask_next = mask_reg;
		if (wr) begin
			unique case (PADDR)
				`ADDR_RX_STATUS_CTRL: rxc_next = PWDATA[`RXC_PORT_ENABLE:`RXC_CONT_RX_ENABLE];
				`ADDR_TX_STATUS_CTRL: txc_next = {PWDATA[`TXC_CLOCK_SOURCE:`TXC_SYNC_SELECT], PWDATA[`TXC_TX_NINTH_BIT]};
				`ADDR_BAUD_CTRL: baud_ctrl_next = PWDATA[7:0];
				`ADDR_BAUD_DIV_HIGH: baud_hi_next = PWDATA[7:0];
				`ADDR_BAUD_DIV_LOW: baud_lo_next = PWDATA[7:0];
				`ADDR_IRQ_MASK: mask_next = PWDATA[2:0];
				`ADDR_CORE_IRQ_CTRL: ien_next = PWDATA[`CIC_GLOBAL_IRQ_ENABLE:`CIC_TX_IRQ_ENABLE];
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// link: transmit and receive shifters

	always_comb begin
		hold_next = hold_reg;
		hold_full_next = hold_full_reg;
		tx_shift_next = tx_shift_reg;
		tx_busy_next = tx_busy_reg;
		tx_cnt_next = tx_cnt_reg;
		dt_out_next = dt_out_reg;
		dt_oe_next = 1'b0;
		rx_shift_next = rx_shift_reg;
		rx_cnt_next = rx_cnt_reg;
		overrun_next = overrun_reg;
		tx_load = 1'b0;
		rx_push = 1'b0;
		ovr_event = 1'b0;
		rx_char = rxc_reg.rx_ninth_enable ? {dt_s, rx_shift_reg[8:1]} : {1'b0, dt_s, rx_shift_reg[8:2]}; // RULE14
		if (!rxc_reg.port_enable) begin // RULE15
			hold_full_next = 1'b0;
			tx_busy_next = 1'b0;
			tx_cnt_next = 4'h0;
			dt_out_next = 1'b0;
			rx_cnt_next = 4'h0;
			overrun_next = 1'b0;
		end else begin
			if (mode == sync_serial_pkg::LINK_TX) begin
				dt_oe_next = 1'b1;
				if (!tx_busy_reg && hold_full_reg) begin // RULE1 RULE3
					tx_shift_next = {txc_reg.tx_ninth_bit, hold_reg}; // RULE7
					tx_busy_next = 1'b1;
					tx_cnt_next = 4'h0;
					hold_full_next = 1'b0;
					tx_load = 1'b1;
				end else if (tx_busy_reg && ck_rise) begin // RULE16
					dt_out_next = tx_shift_reg[0];
					tx_shift_next = tx_shift_reg >> 1;
				end else if (tx_busy_reg && ck_fall) begin
					if (tx_cnt_reg == tx_bits - 4'h1) begin
						tx_busy_next = 1'b0;
					end else begin
						tx_cnt_next = tx_cnt_reg + 4'h1;
					end
				end
			end
			if (mode == sync_serial_pkg::LINK_RX && !overrun_reg && ck_fall) begin // RULE9 RULE11 RULE16 RULE17
				rx_shift_next = {dt_s, rx_shift_reg[8:1]};
				if (rx_cnt_reg == rx_bits - 4'h1) begin
					rx_cnt_next = 4'h0;
					if (fifo_count == `FIFO_DEPTH && !rd_pop) begin // RULE17
						overrun_next = 1'b1;
						ovr_event = 1'b1;
					end else begin
						rx_push = 1'b1; // RULE13
					end
				end else begin
					rx_cnt_next = rx_cnt_reg + 4'h1;
				end
			end
			if (!rxc_reg.continuous_rx_enable) begin // RULE15
				overrun_next = 1'b0;
				rx_cnt_next = 4'h0;
			end
			if (wr && PADDR == `ADDR_TX_HOLDING) begin // RULE8
				hold_next = PWDATA[7:0];
				hold_full_next = 1'b1;
			end
		end
	end

	rx_fifo u_rx_fifo (
		.clk(CLK),
		.rst(SYS_RST),
		.flush(!rxc_reg.port_enable),
		.push(rx_push),
		.din(rx_char),
		.pop(rd_pop),
		.dout(fifo_top),
		.count(fifo_count)
	);

	////////////////////////////////////////////////////////////////////////////
	// interrupts and wake-up

	always_comb begin
		evt_next = evt_reg;
		if (wr && PADDR == `ADDR_IRQ_STATUS) begin
			evt_next = evt_reg & ~PWDATA[2:0];
		end
		evt_next[`EVT_RX_CHAR] = evt_next[`EVT_RX_CHAR] | rx_push; // RULE13
		evt_next[`EVT_TX_BUFFER] = evt_next[`EVT_TX_BUFFER] | tx_load; // RULE3
		evt_next[`EVT_OVERRUN] = evt_next[`EVT_OVERRUN] | ovr_event;
		irq_next = |(evt_reg & mask_reg);
		wake_next = SLEEP && ((ien_reg.peripheral_irq_enable && ien_reg.tx_irq_enable && tx_flag) // RULE4
			|| (ien_reg.rx_irq_enable && rx_flag)); // RULE11 RULE12
		cpu_int_next = ien_reg.global_irq_enable && ((ien_reg.peripheral_irq_enable && ien_reg.tx_irq_enable && tx_flag)
			|| (ien_reg.rx_irq_enable && rx_flag)); // RULE4 RULE12 RULE13
	end

	////////////////////////////////////////////////////////////////////////////
	// state registers

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ck_prev_reg <= 1'b0;
			rxc_reg <= '0;
			txc_reg <= '0;
			ien_reg <= '0;
			baud_ctrl_reg <= `RESET_BYTE;
			baud_hi_reg <= `RESET_BYTE;
			baud_lo_reg <= `RESET_BYTE;
			evt_reg <= `RESET_EVT;
			mask_reg <= `RESET_EVT;
			hold_reg <= `RESET_BYTE;
			hold_full_reg <= 1'b0;
			tx_shift_reg <= '0;
			tx_busy_reg <= 1'b0;
			tx_cnt_reg <= 4'h0;
			dt_out_reg <= 1'b0;
			dt_oe_reg <= 1'b0;
			rx_shift_reg <= '0;
			rx_cnt_reg <= 4'h0;
			overrun_reg <= 1'b0;
			ready_reg <= 1'b0;
			slverr_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
			cpu_int_reg <= 1'b0;
		end else begin
			ck_prev_reg <= ck_prev_next;
			rxc_reg <= rxc_next;
			txc_reg <= txc_next;
			ien_reg <= ien_next;
			baud_ctrl_reg <= baud_ctrl_next;
			baud_hi_reg <= baud_hi_next;
			baud_lo_reg <= baud_lo_next;
			evt_reg <= evt_next;
			mask_reg <= mask_next;
			hold_reg <= hold_next;
			hold_full_reg <= hold_full_next;
			tx_shift_reg <= tx_shift_next;
			tx_busy_reg <= tx_busy_next;
			tx_cnt_reg <= tx_cnt_next;
			dt_out_reg <= dt_out_next;
			dt_oe_reg <= dt_oe_next;
			rx_shift_reg <= rx_shift_next;
			rx_cnt_reg <= rx_cnt_next;
			overrun_reg <= overrun_next;
			ready_reg <= ready_next;
			slverr_reg <= slverr_next;
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
			wake_reg <= wake_next;
			cpu_int_reg <= cpu_int_next;
		end
	end

	assign PRDATA = rdata_reg;
	assign PREADY = ready_reg;
	assign PSLVERR = slverr_reg;
	assign DATA_LINE_OUT = dt_out_reg;
	assign DATA_LINE_OE = dt_oe_reg;
	assign IRQ = irq_reg;
	assign WAKE = wake_reg;
	assign CPU_INT = cpu_int_reg;

endmodule

`default_nettype wire

// File: sync_serial_slave_port_properties.sv
`timescale 1ns/10ps
`default_nettype none

module sync_serial_slave_port_properties (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic SLEEP,
	input wire logic CLOCK_LINE_PIN,
	input wire logic DATA_LINE_OUT,
	input wire logic WAKE,
	input wire logic CPU_INT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	chk_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready held longer than one cycle");
	chk_ready_latency: assert property (PSEL && $rose(PENABLE) |=> PREADY)
		else $error("ready missing after access edge");
	chk_ready_cause: assert property (PREADY |-> PSEL && $past(PENABLE))
		else $error("ready without access phase");
	chk_err_ready: assert property (PSLVERR |-> PREADY)
		else $error("error flag outside ready");
	chk_err_decode: assert property (PREADY |-> PSLVERR == (PADDR > 8'h24 || PADDR[1:0] != 2'b00))
		else $error("error flag does not match address decode");
	chk_err_rdzero: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0000_0000)
		else $error("unmapped read returned data");
	chk_rdata_upper: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h00_0000)
		else $error("read data above low byte not zero");
	chk_wake_sleep: assert property (WAKE |-> $past(SLEEP))
		else $error("wake raised outside sleep");
	chk_int_wake: assert property (CPU_INT && $past(SLEEP) |-> WAKE)
		else $error("core interrupt in sleep without wake");
	chk_dout_hold: assert property (CLOCK_LINE_PIN [*8] |-> $stable(DATA_LINE_OUT))
		else $error("data line changed late in clock high phase");
endmodule

////////////////////////////////////////////////////////////////////////////////
bind sync_serial_slave_port sync_serial_slave_port_properties i_chk (
	.CLK(CLK),
	.SYS_RST(SYS_RST),
	.PSEL(PSEL),
	.PENABLE(PENABLE),
	.PWRITE(PWRITE),
	.PADDR(PADDR),
	.PRDATA(PRDATA),
	.PREADY(PREADY),
	.PSLVERR(PSLVERR),
	.SLEEP(SLEEP),
	.CLOCK_LINE_PIN(CLOCK_LINE_PIN),
	.DATA_LINE_OUT(DATA_LINE_OUT),
	.WAKE(WAKE),
	.CPU_INT(CPU_INT)
);

`default_nettype wire

// File: sync_master_model.sv
`timescale 1ns/10ps
`default_nettype none

// synchronous master: clock idles low, stands still between frames
module sync_master_model (
	output logic clk_line,
	output logic data_drive,
	input wire logic data_wire
);
	initial begin
		clk_line = 1'b0;
		data_drive = 1'b0;
	end

	// gap stretches the low phase to act as a slow master
	task automatic xfer(input int n, input logic [8:0] tx, input int gap, output logic [8:0] rx);
		rx = 9'h000;
		#1.3;
		for (int i = 0; i < n; i++) begin
			clk_line = 1'b1;
			data_drive = tx[i];
			#32;
			clk_line = 1'b0;
			rx[i] = data_wire;
			#(32 + gap);
		end
		// released line must not keep showing the last bit
		data_drive = ~data_drive;
	endtask
endmodule

`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
	logic pready, pslverr, dout, doe, irq, wake, cpu_int, clk_line, mdrv, rerr, dwire;
	logic [8:0] got;
	int err_count = 0, check_count = 0, cyc = 0;

	assign dwire = doe ? dout : mdrv;
	always #2 clk = ~clk;

	sync_serial_slave_port i_dut (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SLEEP(sleep),
		.CLOCK_LINE_PIN(clk_line), .DATA_LINE_IN(dwire), .DATA_LINE_OUT(dout), .DATA_LINE_OE(doe), .IRQ(irq),
		.WAKE(wake), .CPU_INT(cpu_int));
	sync_master_model i_mst (.clk_line(clk_line), .data_drive(mdrv), .data_wire(dwire));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h00_0000, d});
	endtask

	task automatic rc(input string n, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, {24'h00_0000, e}, rdat & {24'h00_0000, m});
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic t_regs;
		rc("rx_ctrl_rst", 8'h00, 8'hff, 8'h00);
		rc("core_rst", 8'h24, 8'hff, 8'h00);
		wr(8'h0c, 8'h5a);
		rc("baud_rw", 8'h0c, 8'hff, 8'h5a);
		rc("hold_wo", 8'h04, 8'hff, 8'h00);
		apb(1'b0, 8'h28, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, {31'h0000_0000, rerr});
	endtask

	task automatic t_rx;
		wr(8'h08, 8'h10);
		wr(8'h00, 8'hb0);
		wr(8'h24, 8'h0a);
		wr(8'h20, 8'h00);
		sleep <= 1'b1;
		i_mst.xfer(8, 9'h0a5, 0, got);
		idle(8);
		chk("irq_masked", 1'b0, irq);
		chk("wake_rx", 1'b1, wake);
		chk("int_rx", 1'b1, cpu_int);
		rc("evt_rx", 8'h1c, 8'h01, 8'h01);
		wr(8'h20, 8'h07);
		idle(2);
		chk("irq_on", 1'b1, irq);
		i_mst.xfer(8, 9'h03c, 40, got);
		i_mst.xfer(8, 9'h077, 0, got);
		idle(8);
		rc("overrun", 8'h00, 8'h02, 8'h02);
		rc("evt_ovr", 8'h1c, 8'h04, 8'h04);
		rc("first", 8'h18, 8'hff, 8'ha5);
		rc("avail_one", 8'h24, 8'h20, 8'h20);
		rc("second", 8'h18, 8'hff, 8'h3c);
		rc("avail_none", 8'h24, 8'h20, 8'h00);
		i_mst.xfer(8, 9'h011, 0, got);
		idle(8);
		rc("blocked", 8'h24, 8'h20, 8'h00);
		wr(8'h00, 8'h80);
		rc("ovr_clear", 8'h00, 8'h02, 8'h00);
		wr(8'h1c, 8'h07);
		rc("evt_clr", 8'h1c, 8'h07, 8'h00);
		idle(2);
		chk("irq_off", 1'b0, irq);
		sleep <= 1'b0;
	endtask

	task automatic t_rx9;
		wr(8'h00, 8'hd0);
		i_mst.xfer(9, 9'h15a, 0, got);
		i_mst.xfer(9, 9'h0c3, 0, got);
		i_mst.xfer(9, 9'h1ff, 0, got);
		idle(8);
		rc("ovr_nine", 8'h00, 8'h02, 8'h02);
		rc("ninth_hi", 8'h00, 8'h01, 8'h01);
		rc("low_a", 8'h18, 8'hff, 8'h5a);
		rc("ninth_lo", 8'h00, 8'h01, 8'h00);
		rc("low_b", 8'h18, 8'hff, 8'hc3);
	endtask

	task automatic t_tx;
		wr(8'h00, 8'h00);
		rc("ovr_port", 8'h00, 8'h02, 8'h00);
		wr(8'h08, 8'h71);
		wr(8'h00, 8'h80);
		wr(8'h24, 8'h0d);
		wr(8'h04, 8'h96);
		wr(8'h04, 8'h4b);
		sleep <= 1'b1;
		rc("flag_clr", 8'h24, 8'h10, 8'h00);
		chk("oe_tx", 1'b1, doe);
		chk("no_wake", 1'b0, wake);
		i_mst.xfer(9, 9'h000, 0, got);
		chk("tx_first", 9'h196, got);
		idle(8);
		chk("wake_tx", 1'b1, wake);
		chk("int_tx", 1'b1, cpu_int);
		rc("flag_set", 8'h24, 8'h10, 8'h10);
		wr(8'h24, 8'h05);
		idle(2);
		chk("int_gated", 1'b0, cpu_int);
		chk("wake_kept", 1'b1, wake);
		i_mst.xfer(9, 9'h000, 0, got);
		chk("tx_second", 9'h14b, got);
		wr(8'h08, 8'h31);
		wr(8'h04, 8'hc5);
		i_mst.xfer(8, 9'h000, 0, got);
		chk("tx_eight", 9'h0c5, got);
		wr(8'h00, 8'ha0);
		idle(4);
		chk("oe_idle", 1'b0, doe);
		sleep <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			end_sim;
		end
	end

	initial begin
		idle(16);
		rst <= 1'b0;
		t_regs;
		t_rx;
		t_rx9;
		t_tx;
		end_sim;
	end
endmodule

`default_nettype wire
